//--- shared/ppt_pkg.sv
// Constants, register map and types for the peak power tracker
package ppt_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_MS = 1;
	localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] INTERVAL_MIN_MS = 16'h0005;
	localparam logic [15:0] INTERVAL_MAX_MS = 16'hEA60;
	localparam logic [15:0] INTERVAL_RST_MS = 16'h0064;
	// ------------------------------------------------------------
	// Sizes and limits
	// ------------------------------------------------------------
	localparam int NPTS = 100;
	localparam logic [6:0] IDX_LAST = 7'h63;
	localparam logic [6:0] POINT_MIN = 7'h01;
	localparam logic [6:0] POINT_MAX = 7'h64;
	localparam logic [15:0] VSTEP = 16'h0010;
	localparam logic [15:0] CURRENT_MAX = 16'hFFFF;
	localparam logic [31:0] POWER_MAX = 32'hFFFFFFFF;
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OCV = 8'h04;
	localparam logic [7:0] REG_SCC = 8'h08;
	localparam logic [7:0] REG_INTERVAL = 8'h0C;
	localparam logic [7:0] REG_TOLERANCE = 8'h10;
	localparam logic [7:0] REG_FAST_V = 8'h14;
	localparam logic [7:0] REG_FAST_P = 8'h18;
	localparam logic [7:0] REG_RANGE = 8'h1C;
	localparam logic [7:0] REG_REPEATS = 8'h20;
	localparam logic [7:0] REG_POINT = 8'h24;
	localparam logic [7:0] REG_STATUS = 8'h28;
	localparam logic [7:0] REG_PEAK_V = 8'h2C;
	localparam logic [7:0] REG_PEAK_I = 8'h30;
	localparam logic [7:0] REG_PEAK_P = 8'h34;
	localparam logic [7:0] REG_RES_IDX = 8'h38;
	localparam logic [7:0] REG_RES_V = 8'h3C;
	localparam logic [7:0] REG_RES_I = 8'h40;
	localparam logic [7:0] REG_RES_P = 8'h44;
	// ------------------------------------------------------------
	// Fields
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_START_BIT = 4;
	localparam int CTRL_STOP_BIT = 5;
	localparam int CTRL_SEP_BIT = 8;
	localparam int RANGE_LAST_LSB = 16;
	localparam int POINT_IDX_LSB = 16;
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_FAST = 2'h1;
	localparam logic [1:0] MODE_CURVE = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CURVE, ST_SCAN} state_t;
endpackage

//--- shared/interval_if.sv
// Carrier between sequencer and its interval timer
`timescale 1ns/1ps
interface interval_if;
	logic start;
	logic [15:0] interval_ms;
	logic expire;
	modport ctrl (output start, output interval_ms, input expire);
	modport timer (input start, input interval_ms, output expire);
endinterface

//--- hdl/interval_timer.sv
// One-shot millisecond interval timer
`timescale 1ns/1ps
module interval_timer import ppt_pkg::*; #(
	parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	interval_if.timer tif
);
	logic [31:0] cyc_q;
	logic [15:0] ms_q;
	logic [15:0] len_q;
	logic run_q;
	logic expire_q;

	// ------------------------------------------------------------
	// Counting
	// ------------------------------------------------------------
	// A new start restarts the count, so a late expire never leaks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q <= 32'h0;
			ms_q <= 16'h0;
			len_q <= 16'h0;
			run_q <= 1'b0;
			expire_q <= 1'b0;
		end else begin
			expire_q <= 1'b0;
			if (tif.start) begin
				cyc_q <= 32'h0;
				ms_q <= 16'h0;
				len_q <= tif.interval_ms;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cyc_q == 32'(MS_CYCLES - 1)) begin
					cyc_q <= 32'h0;
					ms_q <= ms_q + 16'h1;
					if (ms_q + 16'h1 >= len_q) begin
						run_q <= 1'b0;
						expire_q <= 1'b1;
					end
				end else begin
					cyc_q <= cyc_q + 32'h1;
				end
			end
		end
	end

	assign tif.expire = expire_q;
endmodule // interval_timer

//--- hdl/peak_power_tracker.sv
// Peak power tracking sequencer with register port
// How it works
// RQ1: Continuous tracking never ends by itself once the peak is found.
// RQ2: Lower voltage until power falls tolerance below peak, then raise back.
// RQ3: Voltage and current are sampled once per interval of 5 to 60000 ms.
// RQ4: Power tolerance is programmable from zero and sets the reversal band.
// RQ5: Fast track starts at the given peak voltage and power, then tracks.
// RQ6: Latest peak voltage, current and power are always readable.
// RQ7: Curve mode applies user voltage points and stores one result per point.
// RQ8: Only points from first to last index, each 1 to 100, are run.
// RQ9: Each curve point is held for the programmed interval before advancing.
// RQ10: Repetition count 0 to 65535 sets how often the sweep repeats.
// RQ11: At curve end or interrupt the input switches off, results readable.
// RQ12: After a curve the result with greatest power becomes the peak.
// RQ13: Export always walks exactly 100 result sets in point order.
// RQ14: Unprogrammed curve points read as 0 V.
// RQ15: Curve mode holds current and power limits at maximum.
// RQ16: Imported curve files carry exactly 100 voltages, one per row.
// RQ17: A separator setting selects dot or comma for curve files.
// RQ18: Curve data is loaded only while the power input is off.
// RQ19: The search starts slightly above the open circuit voltage.
// RQ20: Tracking never draws more than the short circuit current.
// RQ21: Stop aborts at the next interval boundary, input off, back to idle.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module peak_power_tracker import ppt_pkg::*; #(
	parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [31:0] rdata,
	input wire logic [15:0] meas_voltage,
	input wire logic [15:0] meas_current,
	output logic [15:0] voltage_setpoint,
	output logic [15:0] current_limit,
	output logic [31:0] power_limit,
	output logic input_on,
	output logic dot_separator_option
);
	interval_if tif ();

	state_t state_q;
	logic [1:0] mode_q;
	logic sep_q;
	logic [15:0] open_circuit_voltage_q;
	logic [15:0] short_circuit_current_q;
	logic [15:0] interval_q;
	logic [31:0] tolerance_q;
	logic [15:0] fast_v_q;
	logic [31:0] fast_p_q;
	logic [6:0] first_q;
	logic [6:0] last_q;
	logic [15:0] repeats_q;
	logic stop_pend_q;
	logic dir_up_q;
	logic located_q;
	logic [15:0] vset_q;
	logic [31:0] peak_ref_q;
	logic [15:0] peak_point_voltage_q;
	logic [15:0] peak_point_current_q;
	logic [31:0] peak_point_power_q;
	logic [6:0] idx_q;
	logic [15:0] pass_q;
	logic [6:0] res_idx_q;
	logic [31:0] rdata_q;
	logic [15:0] pts_mem [NPTS];
	logic [15:0] res_v_mem [NPTS];
	logic [15:0] res_i_mem [NPTS];
	logic [31:0] res_p_mem [NPTS];
	logic [NPTS-1:0] pts_vld_q;
	logic [NPTS-1:0] res_vld_q;
	logic [31:0] meas_power;
	logic [32:0] low_band;
	logic start_w;
	logic stop_w;
	logic pt_wr;
	logic [6:0] pt_idx;
	logic step_w;
	logic curve_done;
	logic [15:0] pt_v_first;
	logic [15:0] pt_v_next;
	logic [6:0] idx_next;
	logic [31:0] rd_d;

	interval_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.tif(tif.timer)
	);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign meas_power = meas_voltage * meas_current;
	assign low_band = {1'b0, meas_power} + {1'b0, tolerance_q};
	assign start_w = we && addr == REG_CTRL && wdata[CTRL_START_BIT] && state_q == ST_IDLE;
	assign stop_w = we && addr == REG_CTRL && wdata[CTRL_STOP_BIT];
	assign pt_idx = wdata[POINT_IDX_LSB +: 7];
	// RQ18: no load while on
	assign pt_wr = we && addr == REG_POINT && !input_on && pt_idx <= IDX_LAST;
	assign step_w = tif.expire;
	assign idx_next = idx_q + 7'h1;
	assign curve_done = idx_q + 7'h1 >= last_q || idx_q == IDX_LAST;
	// RQ14: unset points are 0 V
	assign pt_v_first = pts_vld_q[first_q - 7'h1] ? pts_mem[first_q - 7'h1] : 16'h0;
	assign pt_v_next = pts_vld_q[idx_next] ? pts_mem[idx_next] : 16'h0;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= MODE_CONT;
			sep_q <= 1'b0;
			open_circuit_voltage_q <= 16'h0;
			short_circuit_current_q <= 16'h0;
			interval_q <= INTERVAL_RST_MS;
			tolerance_q <= 32'h0;
			fast_v_q <= 16'h0;
			fast_p_q <= 32'h0;
			first_q <= POINT_MIN;
			last_q <= POINT_MAX;
			repeats_q <= 16'h0;
		end else if (we) begin
			case (addr)
				REG_CTRL: begin
					if (state_q == ST_IDLE) begin
						mode_q <= wdata[CTRL_MODE_LSB +: 2];
					end
					// RQ17: separator choice
					sep_q <= wdata[CTRL_SEP_BIT];
				end
				REG_OCV: open_circuit_voltage_q <= wdata[15:0];
				REG_SCC: short_circuit_current_q <= wdata[15:0];
				// RQ3: interval clamped to range
				REG_INTERVAL: begin
					if (wdata[15:0] < INTERVAL_MIN_MS) begin
						interval_q <= INTERVAL_MIN_MS;
					end else if (wdata[15:0] > INTERVAL_MAX_MS) begin
						interval_q <= INTERVAL_MAX_MS;
					end else begin
						interval_q <= wdata[15:0];
					end
				end
				// RQ4: tolerance from zero up
				REG_TOLERANCE: tolerance_q <= wdata;
				REG_FAST_V: fast_v_q <= wdata[15:0];
				REG_FAST_P: fast_p_q <= wdata;
				// RQ8: indices held within 1 to 100
				REG_RANGE: begin
					first_q <= (wdata[6:0] < POINT_MIN) ? POINT_MIN : (wdata[6:0] > POINT_MAX) ? POINT_MAX : wdata[6:0];
					last_q <= (wdata[RANGE_LAST_LSB +: 7] < POINT_MIN) ? POINT_MIN :
						(wdata[RANGE_LAST_LSB +: 7] > POINT_MAX) ? POINT_MAX : wdata[RANGE_LAST_LSB +: 7];
				end
				REG_REPEATS: repeats_q <= wdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Point and result storage
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (pt_wr) begin
			pts_mem[pt_idx] <= wdata[15:0];
		end
		// RQ7: one result set per point
		if (state_q == ST_CURVE && step_w) begin
			res_v_mem[idx_q] <= meas_voltage;
			res_i_mem[idx_q] <= meas_current;
			res_p_mem[idx_q] <= meas_power;
		end
	end

	for (genvar g = 0; g < NPTS; g++) begin : g_entry
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				pts_vld_q[g] <= 1'b0;
				res_vld_q[g] <= 1'b0;
			end else begin
				if (pt_wr && pt_idx == 7'(g)) begin
					pts_vld_q[g] <= 1'b1;
				end
				if (state_q == ST_CURVE && step_w && idx_q == 7'(g)) begin
					res_vld_q[g] <= 1'b1;
				end else if (start_w && mode_q == MODE_CURVE) begin
					res_vld_q[g] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Stop request
	// ------------------------------------------------------------
	// Set wins over the clear made by a fresh start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_pend_q <= 1'b0;
		end else if (stop_w) begin
			stop_pend_q <= 1'b1;
		end else if (start_w) begin
			stop_pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			dir_up_q <= 1'b0;
			located_q <= 1'b0;
			vset_q <= 16'h0;
			peak_ref_q <= 32'h0;
			idx_q <= 7'h0;
			pass_q <= 16'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_w) begin
						dir_up_q <= 1'b0;
						located_q <= 1'b0;
						pass_q <= 16'h0;
						if (mode_q == MODE_CURVE) begin
							state_q <= ST_CURVE;
							idx_q <= first_q - 7'h1;
							vset_q <= pt_v_first;
						end else if (mode_q == MODE_FAST) begin
							// RQ5: jump to given peak
							state_q <= ST_TRACK;
							vset_q <= fast_v_q;
							peak_ref_q <= fast_p_q;
							located_q <= 1'b1;
						end else begin
							// RQ19: start above open circuit
							state_q <= ST_TRACK;
							vset_q <= open_circuit_voltage_q + VSTEP;
							peak_ref_q <= 32'h0;
						end
					end
				end
				ST_TRACK: begin
					if (step_w) begin
						// RQ21: abort at boundary
						if (stop_pend_q) begin
							state_q <= ST_IDLE;
						end else begin
							// RQ1: no end once located
							if (meas_power > peak_ref_q) begin
								peak_ref_q <= meas_power;
							end
							// RQ2: zigzag reversal
							if (!dir_up_q && low_band < {1'b0, peak_ref_q}) begin
								dir_up_q <= 1'b1;
								located_q <= 1'b1;
								vset_q <= vset_q + VSTEP;
							end else if (dir_up_q && meas_power >= peak_ref_q) begin
								dir_up_q <= 1'b0;
								vset_q <= (vset_q > VSTEP) ? vset_q - VSTEP : 16'h0;
							end else if (dir_up_q) begin
								vset_q <= vset_q + VSTEP;
							end else begin
								vset_q <= (vset_q > VSTEP) ? vset_q - VSTEP : 16'h0;
							end
						end
					end
				end
				ST_CURVE: begin
					// RQ9: advance after dwell
					if (step_w) begin
						if (stop_pend_q) begin
							state_q <= ST_SCAN;
							idx_q <= 7'h0;
						end else if (curve_done) begin
							// RQ10: repeat sweep
							if (pass_q == repeats_q) begin
								state_q <= ST_SCAN;
								idx_q <= 7'h0;
							end else begin
								pass_q <= pass_q + 16'h1;
								idx_q <= first_q - 7'h1;
								vset_q <= pt_v_first;
							end
						end else begin
							idx_q <= idx_next;
							vset_q <= pt_v_next;
						end
					end
				end
				ST_SCAN: begin
					// RQ12: walk all sets for the best
					if (idx_q == IDX_LAST) begin
						state_q <= ST_IDLE;
					end else begin
						idx_q <= idx_next;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Every new step restarts the dwell timer
	assign tif.start = start_w || ((state_q == ST_TRACK || state_q == ST_CURVE) && step_w);
	assign tif.interval_ms = interval_q;

	// ------------------------------------------------------------
	// Peak values
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			peak_point_voltage_q <= 16'h0;
			peak_point_current_q <= 16'h0;
			peak_point_power_q <= 32'h0;
		end else if (start_w && mode_q == MODE_CURVE) begin
			peak_point_power_q <= 32'h0;
		end else if (state_q == ST_TRACK && step_w && meas_power > peak_ref_q) begin
			// RQ6: latest acquired peak
			peak_point_voltage_q <= meas_voltage;
			peak_point_current_q <= meas_current;
			peak_point_power_q <= meas_power;
		end else if (state_q == ST_SCAN && res_vld_q[idx_q] && res_p_mem[idx_q] > peak_point_power_q) begin
			peak_point_voltage_q <= res_v_mem[idx_q];
			peak_point_current_q <= res_i_mem[idx_q];
			peak_point_power_q <= res_p_mem[idx_q];
		end
	end

	// ------------------------------------------------------------
	// Outputs to the power stage
	// ------------------------------------------------------------
	// RQ11: input off outside a run
	assign input_on = state_q == ST_TRACK || state_q == ST_CURVE;
	assign voltage_setpoint = vset_q;
	// RQ15: curve runs on voltage alone
	// RQ20: tracking current ceiling
	assign current_limit = (state_q == ST_CURVE) ? CURRENT_MAX : short_circuit_current_q;
	assign power_limit = POWER_MAX;
	assign dot_separator_option = sep_q;

	// ------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------
	always_comb begin
		rd_d = 32'h0;
		case (addr)
			REG_CTRL: rd_d = {23'h0, sep_q, 6'h0, mode_q};
			REG_OCV: rd_d = {16'h0, open_circuit_voltage_q};
			REG_SCC: rd_d = {16'h0, short_circuit_current_q};
			REG_INTERVAL: rd_d = {16'h0, interval_q};
			REG_TOLERANCE: rd_d = tolerance_q;
			REG_FAST_V: rd_d = {16'h0, fast_v_q};
			REG_FAST_P: rd_d = fast_p_q;
			REG_RANGE: rd_d = {9'h0, last_q, 9'h0, first_q};
			REG_REPEATS: rd_d = {16'h0, repeats_q};
			REG_STATUS: rd_d = {9'h0, idx_q, pass_q[7:0], 2'h0, stop_pend_q, located_q, input_on, dir_up_q, 2'(state_q)};
			REG_PEAK_V: rd_d = {16'h0, peak_point_voltage_q};
			REG_PEAK_I: rd_d = {16'h0, peak_point_current_q};
			REG_PEAK_P: rd_d = peak_point_power_q;
			REG_RES_IDX: rd_d = {25'h0, res_idx_q};
			REG_RES_V: rd_d = res_vld_q[res_idx_q] ? {16'h0, res_v_mem[res_idx_q]} : 32'h0;
			REG_RES_I: rd_d = res_vld_q[res_idx_q] ? {16'h0, res_i_mem[res_idx_q]} : 32'h0;
			REG_RES_P: rd_d = res_vld_q[res_idx_q] ? res_p_mem[res_idx_q] : 32'h0;
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= re ? rd_d : 32'h0;
		end
	end
	assign rdata = rdata_q;

	// RQ13: export walk wraps after 100 sets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res_idx_q <= 7'h0;
		end else if (we && addr == REG_RES_IDX) begin
			res_idx_q <= (wdata[6:0] > IDX_LAST) ? IDX_LAST : wdata[6:0];
		end else if (re && addr == REG_RES_P) begin
			res_idx_q <= (res_idx_q == IDX_LAST) ? 7'h0 : res_idx_q + 7'h1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	curve_limits_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
		state_q == ST_CURVE |-> current_limit == CURRENT_MAX && power_limit == POWER_MAX)
		else $error("curve limits not at maximum");
	track_limit_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ20
		state_q == ST_TRACK |-> current_limit == short_circuit_current_q)
		else $error("tracking current limit wrong");
	stop_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ21
		state_q == ST_TRACK && step_w && stop_pend_q |=> state_q == ST_IDLE && !input_on)
		else $error("stop did not return to idle");
	keep_track_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
		state_q == ST_TRACK && !stop_pend_q && !stop_w |=> state_q == ST_TRACK)
		else $error("tracking ended on its own");
	reverse_up_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
		state_q == ST_TRACK && step_w && !stop_pend_q && !dir_up_q && low_band < {1'b0, peak_ref_q}
		|=> dir_up_q && vset_q == $past(vset_q) + VSTEP)
		else $error("no reversal below band");
	search_start_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ19
		start_w && mode_q == MODE_CONT |=> state_q == ST_TRACK && vset_q == $past(open_circuit_voltage_q) + VSTEP)
		else $error("search start voltage wrong");
	fast_start_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
		start_w && mode_q == MODE_FAST |=> vset_q == $past(fast_v_q) && peak_ref_q == $past(fast_p_q))
		else $error("fast track start wrong");
	curve_range_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
		state_q == ST_CURVE |-> idx_q >= first_q - 7'h1 && idx_q <= IDX_LAST)
		else $error("curve index outside range");
	scan_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
		state_q == ST_SCAN |-> !input_on ##1 (state_q == ST_SCAN || state_q == ST_IDLE))
		else $error("input on after curve");
	read_late_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
		re && addr == REG_PEAK_P |=> rdata == $past(peak_point_power_q))
		else $error("peak power read wrong");
endmodule // peak_power_tracker

//--- testbench/panel_model.sv
// Solar panel model feeding measured voltage and current back to the load
`timescale 1ns/1ps
module panel_model #(
	parameter logic [15:0] OCV = 16'h0300,
	parameter logic [15:0] ISC = 16'h0100,
	parameter logic [15:0] KNEE = 16'h0200
) (
	input wire logic input_on,
	input wire logic [15:0] voltage_setpoint,
	input wire logic [15:0] current_limit,
	output logic [15:0] meas_voltage,
	output logic [15:0] meas_current
);
	// ------------------------------------------------------------
	// Panel curve
	// ------------------------------------------------------------
	// Flat current up to the knee, then linear fall to zero at KNEE + ISC, which equals OCV by default
	function automatic logic [15:0] i_of(input logic [15:0] v);
		if (v <= KNEE)
			return ISC;
		if (v >= KNEE + ISC)
			return 16'h0000;
		return ISC - (v - KNEE);
	endfunction

	// Load caps the draw at its own limit; open input shows OCV
	always_comb begin
		meas_voltage = input_on ? voltage_setpoint : OCV;
		meas_current = 16'h0000;
		if (input_on)
			meas_current = (i_of(voltage_setpoint) > current_limit) ? current_limit : i_of(voltage_setpoint);
	end
endmodule // panel_model

//--- testbench/testbench.sv
// Self-checking bench for the peak power tracker
`timescale 1ns/1ps
module testbench;
	import ppt_pkg::*;
	localparam int MSC = 10;
	localparam int IV = 5 * MSC;
	logic clk, rst_n, we, re, input_on, dot_separator_option;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, power_limit, r, pv, pi, pp;
	logic [15:0] meas_voltage, meas_current, voltage_setpoint, current_limit;
	int n_errors, total_checks, n;

	peak_power_tracker #(.MS_CYCLES(MSC)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .we(we),
		.re(re), .rdata(rdata), .meas_voltage(meas_voltage), .meas_current(meas_current),
		.voltage_setpoint(voltage_setpoint), .current_limit(current_limit), .power_limit(power_limit),
		.input_on(input_on), .dot_separator_option(dot_separator_option));
	panel_model panel (.input_on(input_on), .voltage_setpoint(voltage_setpoint), .current_limit(current_limit),
		.meas_voltage(meas_voltage), .meas_current(meas_current));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Whole run needs about 5200 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// Common tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("errors=%0d checks=%0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic wait_off(input int lim);
		n = 0;
		while (input_on === 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	task automatic peaks();
		rd(REG_PEAK_V, pv);
		rd(REG_PEAK_I, pi);
		rd(REG_PEAK_P, pp);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		chk({15'h0, input_on, voltage_setpoint}, 32'h0);
		rd(REG_INTERVAL, r);
		chk(r, 32'h64);
		rd(REG_RANGE, r);
		chk(r, 32'h00640001);
		rd(REG_REPEATS, r);
		chk(r, 32'h0);
		rd(8'hFC, r);
		chk(r, 32'h0);
		wr(REG_INTERVAL, 32'h2);
		rd(REG_INTERVAL, r);
		chk(r, 32'h5);
		wr(REG_INTERVAL, 32'hFFFF);
		rd(REG_INTERVAL, r);
		chk(r, 32'hEA60);
		wr(REG_RANGE, 32'h0);
		rd(REG_RANGE, r);
		chk(r, 32'h00010001);
		wr(REG_CTRL, 32'h100);
		chk({31'h0, dot_separator_option}, 32'h1);
		wr(REG_CTRL, 32'h0);
		chk({31'h0, dot_separator_option}, 32'h0);
		wr(REG_INTERVAL, 32'h5);
	endtask

	task automatic t_track();
		logic [15:0] lo;
		int off, up;
		off = 0;
		up = 0;
		wr(REG_OCV, 32'h300);
		wr(REG_SCC, 32'h100);
		wr(REG_TOLERANCE, 32'h2000);
		wr(REG_CTRL, 32'h10);
		chk({15'h0, input_on, voltage_setpoint}, 32'h10310);
		chk({16'h0, current_limit}, 32'h100);
		lo = voltage_setpoint;
		repeat (70 * IV) begin
			@(posedge clk);
			#1;
			if (input_on !== 1'b1)
				off++;
			if (voltage_setpoint > lo)
				up = 1;
			if (voltage_setpoint < lo)
				lo = voltage_setpoint;
		end
		chk(off, 0);
		chk({16'h0, lo}, 32'h1D0);
		chk(up, 1);
		peaks();
		chk({pv[15:0], pi[15:0]}, 32'h02000100);
		chk(pp, 32'h20000);
		wr(REG_CTRL, 32'h20);
		wait_off(IV + 10);
		chk({31'h0, input_on}, 32'h0);
		rd(REG_STATUS, r);
		chk({30'h0, r[1:0]}, 32'h0);
	endtask

	task automatic t_fast();
		wr(REG_FAST_V, 32'h240);
		wr(REG_FAST_P, 32'h1);
		// Start decodes the stored mode, so the mode goes in first
		wr(REG_CTRL, 32'h1);
		wr(REG_CTRL, 32'h11);
		chk({16'h0, voltage_setpoint}, 32'h240);
		repeat (2 * IV + 10) @(posedge clk);
		#1;
		chk({31'h0, input_on}, 32'h1);
		peaks();
		chk(pi, {16'h0, panel.i_of(pv[15:0])});
		chk(pp, pv * pi);
		chk({pv[15:0], pi[15:0]}, 32'h023000D0);
		wr(REG_CTRL, 32'h20);
		wait_off(IV + 10);
		chk({31'h0, input_on}, 32'h0);
	endtask

	task automatic t_curve();
		logic [15:0] pts [5];
		logic [31:0] ev, ei;
		pts = '{16'h0, 16'h100, 16'h200, 16'h280, 16'h0};
		// Full table load with point 5 left unset; rows outside the range must never run
		for (int k = 0; k < 100; k++)
			if (k != 4)
				wr(REG_POINT, {9'h0, 7'(k), (k >= 1 && k <= 3) ? pts[k] : 16'h02C0});
		wr(REG_RANGE, 32'h00050002);
		wr(REG_REPEATS, 32'h1);
		wr(REG_CTRL, 32'h2);
		wr(REG_CTRL, 32'h12);
		chk({current_limit, voltage_setpoint}, 32'hFFFF0100);
		chk(power_limit, 32'hFFFFFFFF);
		wait_off(500);
		chk({31'h0, n >= 400 && n <= 420}, 32'h1);
		repeat (120) @(posedge clk);
		rd(REG_STATUS, r);
		chk({30'h0, r[1:0]}, 32'h0);
		peaks();
		chk({pv[15:0], pi[15:0]}, 32'h02000100);
		chk(pp, 32'h20000);
		wr(REG_RES_IDX, 32'h0);
		for (int k = 0; k < 100; k++) begin
			ev = (k >= 1 && k <= 4) ? {16'h0, pts[k]} : 32'h0;
			ei = (k >= 1 && k <= 4) ? {16'h0, panel.i_of(pts[k])} : 32'h0;
			rd(REG_RES_V, r);
			chk(r, ev);
			rd(REG_RES_I, r);
			chk(r, ei);
			rd(REG_RES_P, r);
			chk(r, ev * ei);
		end
		rd(REG_RES_IDX, r);
		chk(r, 32'h0);
	endtask

	initial begin
		rst_n = 1'b0;
		we = 1'b0;
		re = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		n_errors = 0;
		total_checks = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		t_regs();
		t_track();
		t_fast();
		t_curve();
		give_verdict();
	end
endmodule // testbench
